/* File: verif/pxf_pin_model.sv */
// External circuits driving the block's input pins
`timescale 1ns/10ps
`default_nettype none
module pxf_pin_model (
    input wire logic clk_sys_i, // Clock
    input wire logic [5:0] lvl_i, // Requested pin levels
    output logic [5:0] pin_o // Pin levels
);
    // Pins move just after an edge, as an unrelated board would
    always @(posedge clk_sys_i) pin_o <= lvl_i;
endmodule : pxf_pin_model
`default_nettype wire

/* File: verif/pxf_top_monitor.sv */
// Port checks for the pin function and prescaler block
`timescale 1ns/10ps
`default_nettype none
module pxf_top_monitor #(
    parameter bit ADC_EXT = 1'b0, // Converter clock from pin
    parameter bit SER_MSB = 1'b1, // Serial bit order
    parameter int DIV_SEL = 1 // Prescaler divide
) (
    input wire logic clk_sys_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB address
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic standby_o, // Standby
    input wire logic resume_o, // Resume pulse
    input wire logic ext_irq_o, // Interrupt pulse
    input wire logic first_timer_tick_o, // Timer tick
    input wire logic converter_tick_o, // Converter tick
    input wire logic serial_msb_first_o // Bit order
);
    localparam int PER = 6 * (2 ** DIV_SEL);
    logic [15:0] gap_reg, gap_next;
    logic seen_reg, seen_next;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    always_comb begin
        gap_next = first_timer_tick_o ? 16'h0000 : gap_reg + 16'h0001;
        seen_next = seen_reg | first_timer_tick_o;
    end
    // Gap only trusted after a first tick has been seen
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gap_reg <= 16'h0000;
            seen_reg <= 1'b0;
        end else begin
            gap_reg <= gap_next;
            seen_reg <= seen_next;
        end
    end
////////////////////////////////////////////////////////////////////////
    chk_tick_period: assert property (first_timer_tick_o && seen_reg |->
        gap_reg == 16'(PER - 1)) else $error("tick period wrong");
    chk_conv_source: assert property (!ADC_EXT |->
        converter_tick_o == first_timer_tick_o) else $error("conv tick");
    chk_bit_order: assert property (serial_msb_first_o == SER_MSB)
        else $error("bit order wrong");
    chk_resume_standby: assert property (resume_o |->
        $past(standby_o) && !standby_o) else $error("resume bad");
    chk_resume_pulse: assert property (resume_o |=> !resume_o)
        else $error("resume too long");
    chk_standby_exit: assert property ($fell(standby_o) |-> resume_o ||
        $past(psel && penable && pwrite && paddr == pxf_pkg::PXF_ADDR_CTRL))
        else $error("standby dropped");
    chk_ext_interrupt_pin_pulse: assert property (ext_irq_o |=> !ext_irq_o)
        else $error("irq pulse too long");
    chk_unmapped_err: assert property (psel && penable &&
        paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h10))
        else $error("slave error wrong");
    chk_ready_now: assert property (psel && penable |-> pready)
        else $error("not ready");
endmodule : pxf_top_monitor
bind pxf_top pxf_top_monitor #(.ADC_EXT(ADC_EXT), .SER_MSB(SER_MSB),
    .DIV_SEL(DIV_SEL)) pxf_top_monitor_i (.clk_sys_i, .sys_rst_i, .psel,
    .penable, .pwrite, .paddr, .pready, .pslverr, .standby_o, .resume_o,
    .ext_irq_o, .first_timer_tick_o, .converter_tick_o,
    .serial_msb_first_o);
`default_nettype wire

/* File: verif/pxf_top_tb.sv */
// Self-checking bench for the pin function and prescaler block
`timescale 1ns/10ps
`default_nettype none
module pxf_top_tb;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, slv;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [5:0] lvl = 6'h00, pin;
    logic oe, stby, res, ext_interrupt_pin, t1, t2, msb, irq, sst, cko, ckq;
    int errors = 0, check_count = 0, n, m, nres = 0, next = 0, nt2 = 0;
    int nss = 0, k;
    always #2 clk_sys_i = ~clk_sys_i;
    // Pulses counted mid-cycle, away from the edge that launches them
    always @(negedge clk_sys_i) begin
        nres += int'(res);
        next += int'(ext_interrupt_pin);
        nt2 += int'(t2);
        nss += int'(sst);
    end
    pxf_pin_model pxf_pin_model_i (.clk_sys_i, .lvl_i(lvl), .pin_o(pin));
    pxf_top #(.DIV_SEL(1)) pxf_top_i (.clk_sys_i, .sys_rst_i, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .wake_input_pin_i(pin[0]), .edge_detect_pin_i(pin[1]),
        .ext_interrupt_pin_i(pin[2]), .converter_clock_pin_i(pin[3]),
        .second_timer_ext_i(pin[4]), .serial_clock_pin_i(pin[5]),
        .serial_clock_or_clock_out_pin_o(cko), .serial_clock_oe_o(oe),
        .standby_o(stby), .resume_o(res), .ext_irq_o(ext_interrupt_pin),
        .first_timer_tick_o(t1), .second_timer_tick_o(t2),
        .serial_shift_tick_o(sst), .converter_tick_o(),
        .serial_msb_first_o(msb), .irq_o(irq));
////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i) penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys_i);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            errors++;
            tally_and_finish();
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask : apb
    task automatic pins(input logic [5:0] v);
        lvl <= v;
        repeat (8) @(posedge clk_sys_i);
    endtask : pins
    // Bounded wait for a pulse counter to move
    task automatic wt(ref int c);
        for (m = 0; m < 40 && c == 0; m++) @(posedge clk_sys_i);
        if (c == 0) begin
            errors++;
            tally_and_finish();
        end
    endtask : wt
////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0000_0000);
            chk(rd, 32'h0000_0000);
        end
        apb(1'b0, pxf_pkg::PXF_ADDR_CFG, 32'h0000_0000);
        chk(rd, 32'h0000_00DF);
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        chk(32'(slv), 32'h0000_0001);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(32'(msb), 32'h0000_0001);
        chk(32'(oe), 32'h0000_0001);
        pins(6'h01);
        pins(6'h00);
        chk(32'(nres), 32'h0000_0000);
        pins(6'h02);
        apb(1'b0, pxf_pkg::PXF_ADDR_FLAG, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        apb(1'b0, pxf_pkg::PXF_ADDR_FLAG, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        apb(1'b1, pxf_pkg::PXF_ADDR_FLAG, 32'h0000_0000);
        pins(6'h00);
        apb(1'b0, pxf_pkg::PXF_ADDR_FLAG, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, pxf_pkg::PXF_ADDR_STAT, 32'h0000_0007);
        apb(1'b1, pxf_pkg::PXF_ADDR_CTRL, 32'h0000_0004);
        chk(32'(stby), 32'h0000_0001);
        pins(6'h02);
        apb(1'b0, pxf_pkg::PXF_ADDR_FLAG, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        pins(6'h03);
        wt(nres);
        chk(32'(nres), 32'h0000_0001);
        chk(32'(stby), 32'h0000_0000);
        apb(1'b1, pxf_pkg::PXF_ADDR_STAT, 32'h0000_0007);
        apb(1'b1, pxf_pkg::PXF_ADDR_MASK, 32'h0000_0004);
        pins(6'h04);
        wt(next);
        chk(32'(irq), 32'h0000_0001);
        apb(1'b1, pxf_pkg::PXF_ADDR_MASK, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, pxf_pkg::PXF_ADDR_MASK, 32'h0000_0004);
        pins(6'h00);
        chk(32'(next), 32'h0000_0001);
        apb(1'b1, pxf_pkg::PXF_ADDR_STAT, 32'h0000_0004);
        chk(32'(irq), 32'h0000_0000);
        for (n = 0; n < 50 && t1 !== 1'b1; n++) @(posedge clk_sys_i);
        if (n == 50) begin
            errors++;
            tally_and_finish();
        end
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (t1 !== 1'b1 && n < 50);
        chk(32'(n), 32'h0000_000C);
        apb(1'b1, pxf_pkg::PXF_ADDR_CTRL, 32'h0000_0001);
        m = nt2;
        k = nss;
        // 48 cycles hold exactly four prescaler ticks at any phase
        repeat (48) @(posedge clk_sys_i);
        chk(32'(nt2 - m), 32'h0000_0000);
        chk(32'(nss - k), 32'h0000_0004);
        pins(6'h10);
        pins(6'h00);
        chk(32'(nt2 - m), 32'h0000_0001);
        apb(1'b1, pxf_pkg::PXF_ADDR_CTRL, 32'h0000_0002);
        chk(32'(oe), 32'h0000_0000);
        m = nt2;
        k = nss;
        repeat (48) @(posedge clk_sys_i);
        chk(32'(nt2 - m), 32'h0000_0004);
        chk(32'(nss - k), 32'h0000_0000);
        pins(6'h20);
        pins(6'h00);
        chk(32'(nss - k), 32'h0000_0001);
        // Shared pin clock toggles every six cycles at divide by two
        m = 0;
        ckq = cko;
        repeat (48) begin
            @(posedge clk_sys_i);
            m += int'(cko != ckq);
            ckq = cko;
        end
        chk(32'(m), 32'h0000_0008);
        tally_and_finish();
    end
endmodule : pxf_top_tb
`default_nettype wire

/* File: verilog/pxf_pkg.sv */
// Package of constants for the pin extra functions and prescaler block
package pxf_pkg;
    // APB register map
    localparam logic [7:0] PXF_ADDR_FLAG = 8'h00;
    localparam logic [7:0] PXF_ADDR_CTRL = 8'h04;
    localparam logic [7:0] PXF_ADDR_STAT = 8'h08;
    localparam logic [7:0] PXF_ADDR_MASK = 8'h0C;
    localparam logic [7:0] PXF_ADDR_CFG = 8'h10;
    // Field positions
    localparam int PXF_EDGE_BIT = 2;
    localparam int PXF_CTRL_T2EXT = 0;
    localparam int PXF_CTRL_SEREXT = 1;
    localparam int PXF_CTRL_STBY = 2;
    localparam int PXF_EV_WAKE = 0;
    localparam int PXF_EV_EDGE = 1;
    localparam int PXF_EV_EXT_INTERRUPT_PIN = 2;
    localparam int PXF_EV_W = 3;
    // Reset values
    localparam logic [3:0] PXF_FLAG_RST = 4'h0;
    localparam logic [2:0] PXF_CTRL_RST = 3'h0;
    localparam logic [2:0] PXF_EV_RST = 3'h0;
    // Prescaler
    localparam int PXF_INSN_OSC = 6;
    localparam int PXF_DIV_W = 12;
    localparam logic [2:0] PXF_INSN_LAST = 3'(PXF_INSN_OSC - 1);
    localparam logic [11:0] PXF_DIV_RST = 12'h000;
endpackage : pxf_pkg

/* File: verilog/pxf_sync.sv */
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
`default_nettype none
module pxf_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_i, // System clock
    input wire logic sys_rst_i, // Async reset, high
    input wire logic [W-1:0] d_i, // Asynchronous inputs
    output logic [W-1:0] q_o // Synchronised outputs
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s1_next;
    logic [W-1:0] s2_next;

    always_comb begin
        s1_next = d_i;
        s2_next = s1_reg;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
        end
    end

    assign q_o = s2_reg;
endmodule : pxf_sync
`default_nettype wire

/* File: verilog/pxf_top.sv */
// Pin extra functions, edge flags and shared clock prescaler
`timescale 1ns/10ps
`default_nettype none
module pxf_top #(
    parameter bit WAKE_EN = 1'b1, // Wake pin option
    parameter bit EDGE_EN = 1'b1, // Edge detector option
    parameter bit EDGE_RISE = 1'b1, // Edge detector polarity
    parameter bit EXT_INTERRUPT_PIN_EN = 1'b1, // External interrupt option
    parameter bit EXT_INTERRUPT_PIN_RISE = 1'b1, // External interrupt polarity
    parameter bit SER_MSB = 1'b1, // Serial bit order
    parameter bit SER_EN = 1'b1, // Serial interface option
    parameter bit ADC_EXT = 1'b0, // Converter clock from pin
    parameter int DIV_SEL = 1 // Prescaler divide 2**DIV_SEL, 1..12
) (
    input wire logic clk_sys_i, // Oscillator clock
    input wire logic sys_rst_i, // Async reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic wake_input_pin_i, // Wake pin
    input wire logic edge_detect_pin_i, // Edge detector pin
    input wire logic ext_interrupt_pin_i, // External interrupt pin
    input wire logic converter_clock_pin_i, // External converter clock
    input wire logic second_timer_ext_i, // External timer clock
    input wire logic serial_clock_pin_i, // External serial clock in
    output logic serial_clock_or_clock_out_pin_o, // Shared clock pin out
    output logic serial_clock_oe_o, // Shared pin drive enable
    output logic standby_o, // Core held in standby
    output logic resume_o, // Pulse: resume at suspended address
    output logic ext_irq_o, // Pulse: external interrupt edge
    output logic first_timer_tick_o, // Pulse: first timer count
    output logic second_timer_tick_o, // Pulse: second timer count
    output logic serial_shift_tick_o, // Pulse: serial shift clock
    output logic converter_tick_o, // Pulse: converter clock
    output logic serial_msb_first_o, // Serial bit order
    output logic irq_o // Level interrupt
);
    // all options above are parameters, not registers
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [5:0] pin_raw;
    logic [5:0] pin_s;
    assign pin_raw = {serial_clock_pin_i, second_timer_ext_i,
                      converter_clock_pin_i, ext_interrupt_pin_i,
                      edge_detect_pin_i, wake_input_pin_i};

    pxf_sync #(.W(6)) u_sync (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .d_i(pin_raw),
        .q_o(pin_s)
    );

    logic [5:0] pin_d_reg;
    logic [5:0] pin_d_next;
    logic [5:0] rise;
    logic [5:0] fall;
    assign rise = pin_s & ~pin_d_reg;
    assign fall = ~pin_s & pin_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: instruction rate then binary divider
    logic [2:0] osc_cnt_reg;
    logic [2:0] osc_cnt_next;
    logic [11:0] div_reg;
    logic [11:0] div_next;
    logic insn_tick;
    logic pre_tick;
    logic pre_clk;

    always_comb begin
        insn_tick = (osc_cnt_reg == pxf_pkg::PXF_INSN_LAST);
        osc_cnt_next = insn_tick ? 3'h0 : osc_cnt_reg + 3'h1;
        div_next = insn_tick ? div_reg + 12'h001 : div_reg;
    end

    // Tick on the instruction when the selected stage wraps to zero
    assign pre_tick = insn_tick &&
        (div_reg[DIV_SEL-1:0] == {DIV_SEL{1'b1}});
    assign pre_clk = div_reg[DIV_SEL-1];

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic edge_flag_reg;
    logic edge_flag_next;
    logic [2:0] ctrl_reg;
    logic [2:0] ctrl_next;
    logic [2:0] stat_reg;
    logic [2:0] stat_next;
    logic [2:0] mask_reg;
    logic [2:0] mask_next;
    logic resume_reg;
    logic resume_next;
    logic ext_interrupt_pin_reg;
    logic ext_interrupt_pin_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    logic wr;
    logic rd;
    logic hit;
    logic edge_ev;
    logic wake_ev;
    logic ext_interrupt_pin_ev;
    logic [2:0] ev;

    assign hit = (paddr == pxf_pkg::PXF_ADDR_FLAG) ||
                 (paddr == pxf_pkg::PXF_ADDR_CTRL) ||
                 (paddr == pxf_pkg::PXF_ADDR_STAT) ||
                 (paddr == pxf_pkg::PXF_ADDR_MASK) ||
                 (paddr == pxf_pkg::PXF_ADDR_CFG);
    assign wr = psel && penable && pwrite && hit;
    assign rd = psel && !penable && !pwrite;

    // Edge sampling runs on the free clock, so standby does not block it
    assign edge_ev = EDGE_EN &&
        (EDGE_RISE ? rise[1] : fall[1]);
    assign wake_ev = WAKE_EN && ctrl_reg[pxf_pkg::PXF_CTRL_STBY]
        && rise[0];
    assign ext_interrupt_pin_ev = EXT_INTERRUPT_PIN_EN &&
        (EXT_INTERRUPT_PIN_RISE ? rise[2] : fall[2]);
    assign ev = {ext_interrupt_pin_ev, edge_ev, wake_ev};

    always_comb begin
        pin_d_next = pin_s;
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        edge_flag_next = edge_flag_reg;
        if (wr && paddr == pxf_pkg::PXF_ADDR_FLAG) begin
            edge_flag_next = 1'b0;
        end
        if (edge_ev) begin
            edge_flag_next = 1'b1;
        end
        if (wr && paddr == pxf_pkg::PXF_ADDR_CTRL) begin
            ctrl_next = pwdata[2:0];
        end
        if (wake_ev) begin
            ctrl_next[pxf_pkg::PXF_CTRL_STBY] = 1'b0;
        end
        if (wr && paddr == pxf_pkg::PXF_ADDR_MASK) begin
            mask_next = pwdata[2:0];
        end
        stat_next = stat_reg;
        if (wr && paddr == pxf_pkg::PXF_ADDR_STAT) begin
            stat_next = stat_reg & ~pwdata[2:0];
        end
        stat_next = stat_next | ev;
        resume_next = wake_ev;
        ext_interrupt_pin_next = ext_interrupt_pin_ev;
        rdata_next = rdata_reg;
        if (rd) begin
            unique case (paddr)
                pxf_pkg::PXF_ADDR_FLAG:
                    rdata_next = {28'h000_0000, 1'b0, edge_flag_reg, 2'b00};
                pxf_pkg::PXF_ADDR_CTRL: rdata_next = {29'h0000_0000, ctrl_reg};
                pxf_pkg::PXF_ADDR_STAT: rdata_next = {29'h0000_0000, stat_reg};
                pxf_pkg::PXF_ADDR_MASK: rdata_next = {29'h0000_0000, mask_reg};
                pxf_pkg::PXF_ADDR_CFG: rdata_next = {24'h00_0000,
                    SER_EN, SER_MSB, ADC_EXT, EXT_INTERRUPT_PIN_RISE, EDGE_RISE,
                    EXT_INTERRUPT_PIN_EN, EDGE_EN, WAKE_EN};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_d_reg <= 6'h00;
            osc_cnt_reg <= 3'h0;
            div_reg <= pxf_pkg::PXF_DIV_RST;
            edge_flag_reg <= 1'b0;
            ctrl_reg <= pxf_pkg::PXF_CTRL_RST;
            stat_reg <= pxf_pkg::PXF_EV_RST;
            mask_reg <= pxf_pkg::PXF_EV_RST;
            resume_reg <= 1'b0;
            ext_interrupt_pin_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            pin_d_reg <= pin_d_next;
            osc_cnt_reg <= osc_cnt_next;
            div_reg <= div_next;
            edge_flag_reg <= edge_flag_next;
            ctrl_reg <= ctrl_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            resume_reg <= resume_next;
            ext_interrupt_pin_reg <= ext_interrupt_pin_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock distribution
    assign first_timer_tick_o = pre_tick;
    assign second_timer_tick_o = ctrl_reg[pxf_pkg::PXF_CTRL_T2EXT] ?
        rise[4] : pre_tick;
    assign serial_shift_tick_o = ctrl_reg[pxf_pkg::PXF_CTRL_SEREXT] ?
        rise[5] : pre_tick;
    assign converter_tick_o = ADC_EXT ? rise[3] : pre_tick;
    // Shared pin always drives the prescaler clock; only its drive enable depends on the serial mode
    assign serial_clock_or_clock_out_pin_o = pre_clk;
    assign serial_clock_oe_o = !SER_EN ||
        !ctrl_reg[pxf_pkg::PXF_CTRL_SEREXT];
    assign serial_msb_first_o = SER_MSB;
    assign standby_o = ctrl_reg[pxf_pkg::PXF_CTRL_STBY];
    assign resume_o = resume_reg;
    assign ext_irq_o = ext_interrupt_pin_reg;
    assign irq_o = |(stat_reg & mask_reg);

    assign prdata = rdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
endmodule : pxf_top
`default_nettype wire
